// ==== hdl/pbo_pkg.sv ====
// Purpose: Shared constants for the port B register block and its override logic.
// Assumes: APB with 32-bit data; each register takes one aligned word at four times its index.
// Notes: Pins 3 and 2 carry no alternate-function override here.
package pbo_pkg;

	localparam int PBO_PINS = 4;
	localparam int PBO_ADDR_W = 8;
	localparam int PBO_DATA_W = 32;

	// Register indices; the byte address is four times the index.
	localparam logic [5:0] PBO_IDX_PIN_INPUT_LEVELS = 6'h00;
	localparam logic [5:0] PBO_IDX_PIN_DIRECTION = 6'h01;
	localparam logic [5:0] PBO_IDX_PIN_OUTPUT_DATA = 6'h02;
	localparam logic [5:0] PBO_IDX_PIN_PULLUP_ENABLE = 6'h03;
	localparam logic [5:0] PBO_IDX_PORT_CONTROL = 6'h0C;

	// Field positions.
	localparam int PBO_PORT_LSB = 0;
	localparam int PBO_PORT_MSB = 3;
	localparam int PBO_BBM_BIT = 1;

	// Values after reset.
	localparam logic [3:0] PBO_RST_DIRECTION = 4'h0;
	localparam logic [3:0] PBO_RST_OUTPUT_DATA = 4'h0;
	localparam logic [3:0] PBO_RST_PULLUP = 4'h0;
	localparam logic PBO_RST_BBM = 1'b0;
	localparam logic [3:0] PBO_RST_INPUT_ENABLE = 4'hF;

	// Cycles the pin stays tristate when break-before-make turns it into an output.
	localparam int PBO_BBM_CYCLES = 1;

endpackage

// ==== hdl/pbo_override_if.sv ====
// Purpose: Carries alternate-function inputs to the override logic and its per-pin results back.
// Assumes: All signals are on pclk.
// Notes: Result vectors have one bit per pin; pins 3 and 2 stay zero.
`timescale 1ns/10ps
`default_nettype none
interface pbo_override_if;
	logic external_main_clock_selected;
	logic power_down_state;
	logic compare_a_output;
	logic compare_a_enable;
	logic compare_b_output;
	logic compare_b_enable;
	logic pin_change_source_0;
	logic pin_change_source_1;
	logic pin_change_group_enable;
	logic analog_in0_digital_disable;
	logic analog_in1_digital_disable;
	logic [3:0] pullup_override_enable;
	logic [3:0] pullup_override_value;
	logic [3:0] direction_override_enable;
	logic [3:0] direction_override_value;
	logic [3:0] output_value_override_enable;
	logic [3:0] output_value_override_value;
	logic [3:0] input_enable_override_enable;
	logic [3:0] input_enable_override_value;

	modport port_side (
		output external_main_clock_selected, power_down_state,
		output compare_a_output, compare_a_enable, compare_b_output, compare_b_enable,
		output pin_change_source_0, pin_change_source_1, pin_change_group_enable,
		output analog_in0_digital_disable, analog_in1_digital_disable,
		input pullup_override_enable, pullup_override_value,
		input direction_override_enable, direction_override_value,
		input output_value_override_enable, output_value_override_value,
		input input_enable_override_enable, input_enable_override_value
	);

	modport override_side (
		input external_main_clock_selected, power_down_state,
		input compare_a_output, compare_a_enable, compare_b_output, compare_b_enable,
		input pin_change_source_0, pin_change_source_1, pin_change_group_enable,
		input analog_in0_digital_disable, analog_in1_digital_disable,
		output pullup_override_enable, pullup_override_value,
		output direction_override_enable, direction_override_value,
		output output_value_override_enable, output_value_override_value,
		output input_enable_override_enable, input_enable_override_value
	);
endinterface
`default_nettype wire

// ==== hdl/pbo_override.sv ====
// Purpose: Alternate-function override terms for port B pins 1 and 0.
// Assumes: Inputs are steady levels from on-chip logic on the same clock.
// Notes: Purely combinational; the port module registers everything that leaves the block.
`timescale 1ns/10ps
`default_nettype none
module pbo_override (
	pbo_override_if.override_side ovr
);
	import pbo_pkg::*;

	wire ext_clk;
	wire pin1_change;
	wire pin0_change;

	assign ext_clk = ovr.external_main_clock_selected; // see R1
	assign pin1_change = ovr.pin_change_source_1 & ovr.pin_change_group_enable;
	assign pin0_change = ovr.pin_change_source_0 & ovr.pin_change_group_enable;

	// An external clock on pin 1 makes it a bare input with no pull-up.
	assign ovr.pullup_override_enable = {2'b00, ext_clk, 1'b0}; // see R14 see R15
	assign ovr.pullup_override_value = 4'h0; // see R14
	assign ovr.direction_override_enable = {2'b00, ext_clk, 1'b0}; // see R14 see R15
	assign ovr.direction_override_value = 4'h0; // see R14

	assign ovr.output_value_override_enable = {2'b00,
		ext_clk | ovr.compare_b_enable, ovr.compare_a_enable}; // see R4 see R15
	assign ovr.output_value_override_value = {2'b00,
		ext_clk & ovr.compare_b_output, ovr.compare_a_output}; // see R4 see R15

	assign ovr.input_enable_override_enable = {2'b00,
		ext_clk | pin1_change | ovr.analog_in1_digital_disable,
		pin0_change | ovr.analog_in0_digital_disable}; // see R5 see R6
	assign ovr.input_enable_override_value = {2'b00,
		(ext_clk & ~ovr.power_down_state) | (~ext_clk & pin1_change),
		pin0_change}; // see R5 see R6
endmodule
`default_nettype wire

// ==== hdl/pbo_port_b.sv ====
// Purpose: Four-bit port B with software registers on APB and pin 1/0 alternate-function overrides.
// Assumes: Zero-wait APB slave; pins are asynchronous and pass two flip-flops before use.
// Notes: Every pin-facing output is registered, so a register write reaches the pins one
// cycle after the APB access edge, or two for a pin that break-before-make holds back.
// Summary of operation
// R1: The external-clock term is high exactly while the external clock is the main clock.
// R2: The reset-pin-disable term is 1 when its configuration bit is 0 and 0 otherwise.
// R3: The clock-output term is 1 when its configuration bit is 0 and 0 otherwise.
// R4: Pin 1 output is overridden by external clock or compare B enable, with value ext AND compare B.
// R5: Pin 1 input enable is overridden by external_main_clock_selected, gated pin change 1 or analog disable 1.
// R6: Pin 0 input enable is overridden by gated pin change 0 or analog disable 0.
// R7: Bit 1 of the port control register turns on break-before-make for all four pins.
// R8: With break-before-make on, a pin made an output stays tristate for one cycle first.
// R9: Pull-up enable bits 3:0 sit at index 0x03, read/write, reset to 0.
// R10: Output data bits 3:0 sit at index 0x02, read/write, reset to 0.
// R11: Direction bits 3:0 sit at index 0x01, read/write, reset to 0 so all pins are inputs.
// R12: Pin input levels appear in bits 3:0 at index 0x00 and follow the pins.
// R13: An active input enable override sets the digital input on for value 1, off for value 0.
// R14: With the external clock selected pin 1 is forced to input with pull-up off.
// R15: Pin 0 output follows compare A while its enable is set; its pull-up and direction stay free.
// R16: Bits 7:4 of the port registers and all port control bits but bit 1 read zero, ignore writes.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module pbo_port_b (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pbo_pkg::PBO_ADDR_W-1:0] paddr,
	input wire logic [pbo_pkg::PBO_DATA_W-1:0] pwdata,
	output logic [pbo_pkg::PBO_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [pbo_pkg::PBO_PINS-1:0] pin_in,
	output logic [pbo_pkg::PBO_PINS-1:0] pin_out,
	output logic [pbo_pkg::PBO_PINS-1:0] pin_oe,
	output logic [pbo_pkg::PBO_PINS-1:0] pin_pullup,
	output logic [pbo_pkg::PBO_PINS-1:0] pin_input_enable,
	input wire logic external_main_clock_selected,
	input wire logic power_down_state,
	input wire logic sleep_state,
	input wire logic compare_a_output,
	input wire logic compare_a_enable,
	input wire logic compare_b_output,
	input wire logic compare_b_enable,
	input wire logic pin_change_source_0,
	input wire logic pin_change_source_1,
	input wire logic pin_change_group_enable,
	input wire logic analog_in0_digital_disable,
	input wire logic analog_in1_digital_disable,
	input wire logic reset_disable_config_bit,
	input wire logic clock_output_config_bit,
	output logic reset_pin_disable,
	output logic system_clock_output_enable
);
	import pbo_pkg::*;

	function automatic logic reg_hit(input logic [PBO_ADDR_W-1:0] addr, input logic [5:0] idx);
		reg_hit = (addr[1:0] == 2'h0) && (addr[PBO_ADDR_W-1:2] == idx);
	endfunction

	// Software state.
	logic [3:0] pin_direction;
	logic [3:0] pin_output_data;
	logic [3:0] pin_pullup_enable;
	logic break_before_make_enable;
	logic [3:0] bbm_hold;

	// Pin synchroniser; sync_a is read only by sync_b.
	logic [3:0] pin_sync_a;
	logic [3:0] pin_sync_b;

	pbo_override_if ovr_if ();

	assign ovr_if.external_main_clock_selected = external_main_clock_selected; // see R1
	assign ovr_if.power_down_state = power_down_state;
	assign ovr_if.compare_a_output = compare_a_output;
	assign ovr_if.compare_a_enable = compare_a_enable;
	assign ovr_if.compare_b_output = compare_b_output;
	assign ovr_if.compare_b_enable = compare_b_enable;
	assign ovr_if.pin_change_source_0 = pin_change_source_0;
	assign ovr_if.pin_change_source_1 = pin_change_source_1;
	assign ovr_if.pin_change_group_enable = pin_change_group_enable;
	assign ovr_if.analog_in0_digital_disable = analog_in0_digital_disable;
	assign ovr_if.analog_in1_digital_disable = analog_in1_digital_disable;

	pbo_override u_override (
		.ovr(ovr_if.override_side)
	);

	// APB decode.
	wire setup_phase;
	wire access_done;
	wire hit_levels;
	wire hit_direction;
	wire hit_output;
	wire hit_pullup;
	wire hit_control;
	wire addr_mapped;
	wire wr_direction;
	wire wr_output;
	wire wr_pullup;
	wire wr_control;

	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign hit_levels = reg_hit(paddr, PBO_IDX_PIN_INPUT_LEVELS);
	assign hit_direction = reg_hit(paddr, PBO_IDX_PIN_DIRECTION);
	assign hit_output = reg_hit(paddr, PBO_IDX_PIN_OUTPUT_DATA);
	assign hit_pullup = reg_hit(paddr, PBO_IDX_PIN_PULLUP_ENABLE);
	assign hit_control = reg_hit(paddr, PBO_IDX_PORT_CONTROL);
	assign addr_mapped = hit_levels | hit_direction | hit_output | hit_pullup | hit_control;
	assign wr_direction = access_done & pwrite & hit_direction;
	assign wr_output = access_done & pwrite & hit_output;
	assign wr_pullup = access_done & pwrite & hit_pullup;
	assign wr_control = access_done & pwrite & hit_control;

	// Next values; writes to the input-level register are ignored.
	wire [3:0] next_pin_direction;
	wire [3:0] next_pin_output_data;
	wire [3:0] next_pin_pullup_enable;
	wire next_break_before_make_enable;
	wire [3:0] next_bbm_hold;
	wire [3:0] going_output;

	assign next_pin_direction = wr_direction ? pwdata[PBO_PORT_MSB:PBO_PORT_LSB] :
		pin_direction; // see R11 see R16
	assign next_pin_output_data = wr_output ? pwdata[PBO_PORT_MSB:PBO_PORT_LSB] :
		pin_output_data; // see R10 see R16
	assign next_pin_pullup_enable = wr_pullup ? pwdata[PBO_PORT_MSB:PBO_PORT_LSB] :
		pin_pullup_enable; // see R9 see R16
	assign next_break_before_make_enable = wr_control ? pwdata[PBO_BBM_BIT] :
		break_before_make_enable; // see R7 see R16
	// Only bits turning from input to output are held back; the enable in force before the
	// write decides, so the write that sets the mode does not delay its own pins.
	assign going_output = next_pin_direction & ~pin_direction;
	assign next_bbm_hold = (wr_direction && break_before_make_enable) ?
		going_output : 4'h0; // see R7 see R8

	// Read data, captured in the setup phase so it stands through the access phase.
	wire [3:0] level_view;
	wire read_setup;
	wire [3:0] read_port;
	wire [1:0] read_control;
	wire [PBO_DATA_W-1:0] next_prdata;

	assign level_view = pin_sync_b & pin_input_enable; // see R12 see R13
	assign read_setup = setup_phase & ~pwrite;
	// The four port registers share one narrow mux; the upper bits always read zero.
	assign read_port = hit_levels ? level_view :
		hit_direction ? pin_direction :
		hit_output ? pin_output_data :
		hit_pullup ? pin_pullup_enable :
		4'h0; // see R12 see R16
	assign read_control = hit_control ? {break_before_make_enable, 1'b0} : 2'b00; // see R7 see R16
	assign next_prdata = !read_setup ? 32'h0000_0000 :
		{28'h000_0000, read_port | {2'b00, read_control}}; // see R16

	// Pin composition with overrides applied.
	wire [3:0] soft_direction;
	wire [3:0] next_pin_oe;
	wire [3:0] next_pin_out;
	wire [3:0] next_pin_pullup;
	wire [3:0] next_pin_input_enable;

	// A held pin is seen as input for exactly one cycle.
	assign soft_direction = pin_direction & ~bbm_hold; // see R8

	genvar gi;
	generate
		for (gi = 0; gi < PBO_PINS; gi++) begin : g_pin
			assign next_pin_oe[gi] = ovr_if.direction_override_enable[gi] ?
				ovr_if.direction_override_value[gi] : soft_direction[gi]; // see R14
			assign next_pin_out[gi] = ovr_if.output_value_override_enable[gi] ?
				ovr_if.output_value_override_value[gi] : pin_output_data[gi]; // see R4 see R15
			assign next_pin_pullup[gi] = ovr_if.pullup_override_enable[gi] ?
				ovr_if.pullup_override_value[gi] : pin_pullup_enable[gi]; // see R9 see R14
			// Without an override the input is on while awake and off in sleep.
			assign next_pin_input_enable[gi] = ovr_if.input_enable_override_enable[gi] ?
				ovr_if.input_enable_override_value[gi] : ~sleep_state; // see R13
		end
	endgenerate

	// One short process per register, the two synchroniser stages sharing one, keeps each reset value next to its own update.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_direction <= PBO_RST_DIRECTION;
		end else begin
			pin_direction <= next_pin_direction;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_output_data <= PBO_RST_OUTPUT_DATA;
		end else begin
			pin_output_data <= next_pin_output_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_pullup_enable <= PBO_RST_PULLUP;
		end else begin
			pin_pullup_enable <= next_pin_pullup_enable;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			break_before_make_enable <= PBO_RST_BBM;
		end else begin
			break_before_make_enable <= next_break_before_make_enable;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bbm_hold <= 4'h0;
		end else begin
			bbm_hold <= next_bbm_hold;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sync_a <= 4'h0;
			pin_sync_b <= 4'h0;
		end else begin
			pin_sync_a <= pin_in;
			pin_sync_b <= pin_sync_a;
		end
	end

	// One wait-free access: pready rises for the cycle after setup and falls at completion.
	wire next_pslverr;

	assign next_pslverr = setup_phase & ~addr_mapped; // see R16

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_phase;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= next_pslverr;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else begin
			prdata <= next_prdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_oe <= PBO_RST_DIRECTION;
		end else begin
			pin_oe <= next_pin_oe;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= PBO_RST_OUTPUT_DATA;
		end else begin
			pin_out <= next_pin_out;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_pullup <= PBO_RST_PULLUP;
		end else begin
			pin_pullup <= next_pin_pullup;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_input_enable <= PBO_RST_INPUT_ENABLE;
		end else begin
			pin_input_enable <= next_pin_input_enable;
		end
	end

	// Configuration bits are active low: a programmed bit reads 0.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_pin_disable <= 1'b0;
		end else begin
			reset_pin_disable <= ~reset_disable_config_bit; // see R2
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_clock_output_enable <= 1'b0;
		end else begin
			system_clock_output_enable <= ~clock_output_config_bit; // see R3
		end
	end

endmodule
`default_nettype wire

// ==== verif/pbo_monitor.sv ====
// Purpose: Concurrent checks on the pin-facing outputs of the port B block.
// Assumes: Override inputs and config bits reach the outputs one edge later.
// Notes: Register contents are judged by the bench scoreboard, not here.
`timescale 1ns/10ps
`default_nettype none
module pbo_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic [pbo_pkg::PBO_PINS-1:0] pin_out,
	input wire logic [pbo_pkg::PBO_PINS-1:0] pin_oe,
	input wire logic [pbo_pkg::PBO_PINS-1:0] pin_pullup,
	input wire logic [pbo_pkg::PBO_PINS-1:0] pin_input_enable,
	input wire logic external_main_clock_selected,
	input wire logic power_down_state,
	input wire logic sleep_state,
	input wire logic compare_a_output,
	input wire logic compare_a_enable,
	input wire logic compare_b_output,
	input wire logic compare_b_enable,
	input wire logic pin_change_source_0,
	input wire logic pin_change_source_1,
	input wire logic pin_change_group_enable,
	input wire logic analog_in0_digital_disable,
	input wire logic analog_in1_digital_disable,
	input wire logic reset_disable_config_bit,
	input wire logic clock_output_config_bit,
	input wire logic reset_pin_disable,
	input wire logic system_clock_output_enable
);
	import pbo_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire ext = external_main_clock_selected;
	wire g0 = pin_change_source_0 && pin_change_group_enable;
	wire g1 = pin_change_source_1 && pin_change_group_enable;
	wire v1 = (ext && !power_down_state) || (!ext && g1);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence one_beat_s;
		pready ##1 !pready;
	endsequence
	chk_ready_one_beat: assert property (setup_s |=> one_beat_s)
		else $error("ready not a single beat after setup");
	chk_ext_pin_input: assert property (ext |=> !pin_oe[1] && !pin_pullup[1])
		else $error("pin 1 not forced to input without pull-up");
	chk_pin1_out_value: assert property ((ext || compare_b_enable) |=>
		pin_out[1] == $past(ext && compare_b_output)) else $error("pin 1 output override wrong");
	chk_pin0_out_value: assert property (compare_a_enable |=>
		pin_out[0] == $past(compare_a_output)) else $error("pin 0 output override wrong");
	chk_pin1_in_enable: assert property ((ext || g1 || analog_in1_digital_disable) |=>
		pin_input_enable[1] == $past(v1)) else $error("pin 1 input enable override wrong");
	chk_pin0_in_enable: assert property ((g0 || analog_in0_digital_disable) |=>
		pin_input_enable[0] == $past(g0)) else $error("pin 0 input enable override wrong");
	// The edge that releases reset still loads reset values, so it starts no attempt.
	chk_reset_term: assert property (presetn |=>
		reset_pin_disable == !$past(reset_disable_config_bit)) else $error("reset term wrong");
	chk_clkout_term: assert property (presetn |=>
		system_clock_output_enable == !$past(clock_output_config_bit)) else $error("clkout wrong");
	chk_free_in_enable: assert property (presetn |=>
		pin_input_enable[3:2] == {2{!$past(sleep_state)}}) else $error("free input enable wrong");
endmodule
`default_nettype wire

// ==== verif/pbo_pin_model.sv ====
// Purpose: Board side of the four port B pins.
// Assumes: The bench never drives a pin while the block drives it.
// Notes: A floating pin toggles every cycle so a stale value cannot pass.
`timescale 1ns/10ps
`default_nettype none
module pbo_pin_model (
	input wire logic pclk,
	input wire logic [pbo_pkg::PBO_PINS-1:0] pin_out,
	input wire logic [pbo_pkg::PBO_PINS-1:0] pin_oe,
	input wire logic [pbo_pkg::PBO_PINS-1:0] pin_pullup,
	input wire logic [pbo_pkg::PBO_PINS-1:0] drive_en,
	input wire logic [pbo_pkg::PBO_PINS-1:0] drive_lvl,
	output logic [pbo_pkg::PBO_PINS-1:0] pin_in
);
	import pbo_pkg::*;
	logic [3:0] drift = 4'h5;
	always @(posedge pclk) begin
		drift <= ~drift;
	end
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive_en & drive_lvl)
		| (~pin_oe & ~drive_en & (pin_pullup | drift));
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the port B register and override block.
// Assumes: Zero-wait APB slave; pins settle one edge after a write, two for a pin held by break-before-make.
// Notes: Read and write answers are checked by a scoreboard queue.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import pbo_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic reset_pin_disable, system_clock_output_enable;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pin_in, pin_out, pin_oe, pin_pullup, pin_input_enable;
	logic [3:0] drive_en = 4'h0, drive_lvl = 4'h0;
	logic [13:0] ov = 14'h0;
	logic [32:0] expq[$];
	logic [7:0] ra[4] = '{8'h04, 8'h08, 8'h0C, 8'h30};
	logic [3:0] mk[4] = '{4'hF, 4'hF, 4'hF, 4'h2};
	int err_total = 0, num_checks = 0, seed = 32'hA683;
	always #2.5 pclk = ~pclk;
	pbo_pin_model i_pins (.*);
	pbo_port_b i_dut (.*, .external_main_clock_selected(ov[0]), .power_down_state(ov[1]),
		.sleep_state(ov[2]), .compare_a_output(ov[3]), .compare_a_enable(ov[4]),
		.compare_b_output(ov[5]), .compare_b_enable(ov[6]), .pin_change_source_0(ov[7]),
		.pin_change_source_1(ov[8]), .pin_change_group_enable(ov[9]),
		.analog_in0_digital_disable(ov[10]), .analog_in1_digital_disable(ov[11]),
		.reset_disable_config_bit(ov[12]), .clock_output_config_bit(ov[13]));
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		if (expq.size() != 0) err_total++;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// The request is held until pready is seen; the answer is noted first for the scoreboard.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		expq.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pins(input logic [32:0] e);
		@(posedge pclk);
		#1 check({21'h0, pin_oe, pin_out, pin_pullup}, e);
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready) begin
			if (expq.size() == 0) err_total++;
			else check({pslverr, prdata}, expq.pop_front());
		end
	end
	initial begin
		#50000;
		err_total++;
		wrap_up;
	end
	initial begin
		logic [31:0] w;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ra[i]) apb(0, ra[i], 0, 33'h0);
		foreach (ra[i]) begin
			w = $random(seed);
			apb(1, ra[i], w, 33'h0);
			apb(0, ra[i], 0, {29'h0, w[3:0] & mk[i]});
		end
		apb(1, 8'h10, 32'hF, {1'b1, 32'h0});
		apb(0, 8'h05, 0, {1'b1, 32'h0});
		apb(1, 8'h04, 0, 33'h0);
		apb(1, 8'h0C, 0, 33'h0);
		drive_en <= 4'hF;
		repeat (4) begin
			w = $random(seed);
			drive_lvl <= w[3:0];
			apb(1, 8'h00, ~w, 33'h0);
			apb(0, 8'h00, 0, {29'h0, w[3:0]});
		end
		drive_en <= 4'h0;
		apb(1, 8'h08, 32'h5, 33'h0);
		apb(1, 8'h04, 32'hF, 33'h0);
		apb(1, 8'h0C, 32'hA, 33'h0);
		pins({21'h0, 12'hF5A});
		apb(1, 8'h04, 0, 33'h0);
		apb(1, 8'h30, 32'h2, 33'h0);
		apb(1, 8'h04, 32'h1, 33'h0);
		pins({21'h0, 12'h05A});
		pins({21'h0, 12'h15A});
		apb(1, 8'h30, 0, 33'h0);
		apb(1, 8'h04, 0, 33'h0);
		apb(1, 8'h04, 32'h1, 33'h0);
		pins({21'h0, 12'h15A});
		repeat (60) begin
			@(posedge pclk);
			ov <= 14'($random(seed));
		end
		@(posedge pclk);
		ov <= 14'h0;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h04, 0, 33'h0);
		// Let the scoreboard take the last answer before the verdict.
		@(posedge pclk);
		wrap_up;
	end
endmodule
bind pbo_port_b pbo_monitor i_mon (.*);
`default_nettype wire
